// ===== hw/sesq_pkg.sv
package sesq_pkg;

  // Register offsets on the plain register port (byte addresses)
  localparam logic [7:0] OFF_CMD  = 8'h00;   // Command strobe register
  localparam logic [7:0] OFF_ERR  = 8'h04;   // Error query: read pops one record
  localparam logic [7:0] OFF_STAT = 8'h08;   // Block status
  localparam logic [7:0] OFF_SMO  = 8'h0C;   // Smoothing enable
  localparam logic [7:0] OFF_FLUC = 8'h10;   // Fluctuation threshold, 0.1 % units
  localparam logic [7:0] OFF_PTS  = 8'h14;   // Smoothing point count
  localparam logic [7:0] OFF_BEEP = 8'h18;   // Beeper enable
  localparam logic [7:0] OFF_VERS = 8'h1C;   // Standard version

  // Commands written to the command register
  typedef enum logic [2:0] {
    CMD_NONE   = 3'b000,
    CMD_CLS    = 3'b001,   // Clear status
    CMD_LOCAL  = 3'b010,   // Front panel release
    CMD_LOCK   = 3'b011,   // front_panel_lock_command
    CMD_PRESET = 3'b100,   // Instrument preset
    CMD_RST    = 3'b101    // Factory reset
  } sesq_cmd_type;

  // Front panel state
  typedef enum logic {
    PANEL_LOCAL  = 1'b0,
    PANEL_REMOTE = 1'b1
  } sesq_panel_type;

  // Error records: signed number plus message index, at most 255 characters as text
  localparam int          EQ_DEPTH    = 20;
  localparam int          ERR_STR_MAX = 255;
  localparam logic [15:0] ERR_NONE    = 16'h0000;  // +0
  localparam logic [15:0] ERR_OVF     = 16'hFEA2;  // -350
  localparam logic [15:0] ERR_RANGE   = 16'hFF22;  // -222
  localparam logic [15:0] ERR_UNDEF   = 16'hFF8F;  // -113
  localparam logic [7:0]  MSG_NONE    = 8'h00;     // "No error"
  localparam logic [7:0]  MSG_OVF     = 8'h01;     // "Error queue overflow"
  localparam logic [7:0]  MSG_RANGE   = 8'h02;     // "Data out of range"
  localparam logic [7:0]  MSG_UNDEF   = 8'h03;     // "Undefined header"

  // Read field positions
  localparam int ERR_CODE_LSB  = 16;
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_SUM_BIT  = 1;
  localparam int STAT_ACT_BIT  = 2;
  localparam int STAT_CNT_LSB  = 8;

  // Setting limits and defaults
  localparam logic        SMO_RST   = 1'b0;
  localparam logic        BEEP_RST  = 1'b1;
  localparam logic [6:0]  FLUC_MAX  = 7'h63;   // 9.9 %
  localparam logic [6:0]  FLUC_RST  = 7'h0A;   // 1.0 %
  localparam logic [9:0]  FLUC_SCL  = 10'h3E8; // Tenths of a percent per unit
  localparam logic [10:0] PTS_MIN   = 11'h002;
  localparam logic [10:0] PTS_MAX   = 11'h7CF; // 1999
  localparam logic [10:0] PTS_RST   = 11'h00A;
  localparam logic [15:0] VERS_YEAR = 16'h07CF; // 1999
  localparam logic [7:0]  VERS_REV  = 8'h00;

  // overload_indication encoding
  localparam logic [1:0] OVL_NONE = 2'b00;
  localparam logic [1:0] OVL_POS  = 2'b01;   // Reported as +9.900000E+37
  localparam logic [1:0] OVL_NEG  = 2'b10;   // Reported as -9.900000E+37

endpackage : sesq_pkg

// ===== hw/sesq_eq_if.sv
`timescale 1ns/100ps
interface sesq_eq_if;
  logic        push;       // One record arrives
  logic [15:0] push_code;  // Its error number
  logic [7:0]  push_msg;   // Its message index
  logic        pop;        // Oldest record is taken
  logic        clear;      // Queue is emptied
  logic [15:0] head_code;  // Oldest number, or +0 when empty
  logic [7:0]  head_msg;   // Oldest message index
  logic [4:0]  count;      // Records held

  modport owner (output push, push_code, push_msg, pop, clear,
                 input  head_code, head_msg, count);
  modport queue (input  push, push_code, push_msg, pop, clear,
                 output head_code, head_msg, count);
endinterface : sesq_eq_if

// ===== hw/sesq_err_queue.sv
`timescale 1ns/100ps
module sesq_err_queue #(
  parameter int DEPTH = sesq_pkg::EQ_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  sesq_eq_if.queue q
);
  localparam int PW = $clog2(DEPTH);

  logic [15:0]   code_r [DEPTH];   // Error numbers
  logic [7:0]    msg_r  [DEPTH];   // Message indexes
  logic [PW-1:0] rd_r, wr_r;       // Oldest and next free slot
  logic [4:0]    cnt_r;            // Records held

  // Circular index step
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : step

  ////////////////////////////////////////////////////////////////////////
  // Pointer and count update; a push in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    logic [PW-1:0] rd, wr;
    logic [4:0]    c;
    if (!rst_n) begin
      rd_r  <= '0;
      wr_r  <= '0;
      cnt_r <= '0;
    end else begin
      rd = q.clear ? '0 : rd_r;
      wr = q.clear ? '0 : wr_r;
      c  = q.clear ? '0 : cnt_r;
      if (q.pop && c != '0) begin
        rd = step(rd);
        c  = c - 1'b1;
      end
      if (q.push && c < 5'(DEPTH)) begin
        code_r[wr] <= q.push_code;
        msg_r[wr]  <= q.push_msg;
        wr = step(wr);
        c  = c + 1'b1;
      end else if (q.push) begin
        // Full: newest slot becomes the overflow record, the new one is lost
        code_r[(wr == '0) ? PW'(DEPTH - 1) : wr - 1'b1] <= sesq_pkg::ERR_OVF;
        msg_r[(wr == '0) ? PW'(DEPTH - 1) : wr - 1'b1]  <= sesq_pkg::MSG_OVF;
      end
      rd_r  <= rd;
      wr_r  <= wr;
      cnt_r <= c;
    end
  end

  // Empty queue answers +0 "No error"
  assign q.head_code = (cnt_r == '0) ? sesq_pkg::ERR_NONE : code_r[rd_r];
  assign q.head_msg  = (cnt_r == '0) ? sesq_pkg::MSG_NONE : msg_r[rd_r];
  assign q.count     = cnt_r;

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence full_push_s;
    cnt_r == 5'(DEPTH) && q.push && !q.pop && !q.clear;
  endsequence

  cnt_bound_a: assert property (cnt_r <= 5'(DEPTH))
    else $error("queue holds more than its depth");
  ovf_write_a: assert property (full_push_s |=> cnt_r == 5'(DEPTH)
    && code_r[(wr_r == '0) ? PW'(DEPTH - 1) : wr_r - 1'b1] == sesq_pkg::ERR_OVF)
    else $error("overflow record missing");
  empty_head_a: assert property (cnt_r == '0 |-> q.head_code == sesq_pkg::ERR_NONE)
    else $error("empty queue not answering +0");
  clear_only_a: assert property (q.clear && !q.push |=> cnt_r == '0)
    else $error("clear left records");
endmodule : sesq_err_queue

// ===== hw/sesq_smooth.sv
`timescale 1ns/100ps
module sesq_smooth #(
  parameter int SW = 24,   // Sample width
  parameter int PW = 11    // Point count width
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          smo_en,   // Smoothing enable setting
  input  wire logic [6:0]    fluc,     // Threshold, 0.1 % units
  input  wire logic [PW-1:0] pts,      // Point count
  input  wire logic          trig,     // Trigger mode active
  input  wire logic          s_valid,
  input  wire logic [SW-1:0] s_data,   // Signed reading
  input  wire logic          ov_pos,
  input  wire logic          ov_neg,
  output logic               o_valid,
  output logic [SW-1:0]      o_data,
  output logic [1:0]         o_ovl,
  output logic               o_active
);
  localparam int AW = SW + PW + 1;

  logic signed [AW-1:0] sum_r;    // Running sum
  logic [PW-1:0]        cnt_r;    // Points in sum; zero means restart
  logic signed [SW-1:0] prev_r;   // Previous reading
  logic                 act;
  logic signed [SW-1:0] s;
  logic signed [AW-1:0] sum_nxt;
  logic [PW-1:0]        cnt_nxt;
  logic                 jump;

  // Mean of a sum over a nonzero count
  function automatic logic [SW-1:0] mean(input logic signed [AW-1:0] a,
                                         input logic [PW-1:0] n);
    return SW'(a / $signed({1'b0, n}));
  endfunction : mean

  // Magnitude, widened so the threshold products cannot wrap
  function automatic logic [39:0] mag(input logic signed [SW-1:0] v);
    return 40'(v < 0 ? -v : v);
  endfunction : mag

  assign s   = $signed(s_data);
  assign act = smo_en && !trig;

  ////////////////////////////////////////////////////////////////////////
  // Next running sum; a step beyond a nonzero threshold restarts the average
  always_comb begin
    jump = fluc != '0 && cnt_r != '0
      && mag(s - prev_r) * 40'(sesq_pkg::FLUC_SCL) > 40'(fluc) * mag(prev_r);
    if (jump || cnt_r == '0) begin
      sum_nxt = AW'(s);
      cnt_nxt = PW'(1);
    end else if (cnt_r < pts) begin
      sum_nxt = sum_r + AW'(s);
      cnt_nxt = cnt_r + 1'b1;
    end else begin
      // Window full: drop one mean point to keep storage small
      sum_nxt = sum_r - AW'($signed(mean(sum_r, cnt_r))) + AW'(s);
      cnt_nxt = cnt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample handling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_r   <= '0;
      cnt_r   <= '0;
      prev_r  <= '0;
      o_valid <= 1'b0;
      o_data  <= '0;
      o_ovl   <= sesq_pkg::OVL_NONE;
    end else begin
      o_valid <= s_valid;
      if (s_valid && (ov_pos || ov_neg)) begin
        o_ovl  <= ov_pos ? sesq_pkg::OVL_POS : sesq_pkg::OVL_NEG;
        o_data <= '0;
        cnt_r  <= '0;     // Restart once back in range
      end else if (s_valid && !act) begin
        o_ovl  <= sesq_pkg::OVL_NONE;
        o_data <= s_data;
        cnt_r  <= '0;     // Suspended: fresh average on resume
        prev_r <= s;
      end else if (s_valid) begin
        o_ovl  <= sesq_pkg::OVL_NONE;
        o_data <= mean(sum_nxt, cnt_nxt);
        sum_r  <= sum_nxt;
        cnt_r  <= cnt_nxt;
        prev_r <= s;
      end
    end
  end

  // Effective smoothing state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) o_active <= 1'b0;
    else o_active <= act;
  end
endmodule : sesq_smooth

// ===== hw/sesq_top.sv
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/100ps
// Function
// - Error queue holds at most twenty records
// - Error query returns and removes oldest record
// - Overflow replaces newest with -350, drops rest
// - Empty queue query answers +0, no error
// - Record is number, comma, quoted message
// - Beep once per syntax or hardware error
// - Beeps only while beeper enable is on
// - Queue not empty shown in status summary
// - Clear status empties queue; reset does not
// - Release command enters local, keys work
// - Lock command enters remote, keys ignored
// - Preset does exactly what factory reset does
// - Smoothing enable takes 0/1, default 0
// - Overload flagged by sign; smoothing then restarts
// - Trigger mode suspends smoothing until left
// - Smoothing settings survive reset, preset, power; here the power-up reset reloads their defaults
// - Threshold 0.0 to 9.9 %, default 1.0
// - Step beyond threshold restarts the average; here a threshold of 0.0 turns the check off
// - Point count 2 to 1999, default 10
// - Version answers year and revision in year
module sesq_top #(
  parameter int          SW        = 24,
  parameter int          PW        = 11,
  parameter logic [15:0] VERS_YEAR = sesq_pkg::VERS_YEAR,
  parameter logic [7:0]  VERS_REV  = sesq_pkg::VERS_REV
) (
  input  wire logic          REF_CLK,
  input  wire logic          NRST,
  input  wire logic [7:0]    ADDR,
  input  wire logic [31:0]   WDATA,
  input  wire logic          WR,
  input  wire logic          RD,
  output logic [31:0]        RDATA,
  input  wire logic          ERR_VALID,
  input  wire logic [15:0]   ERR_CODE,
  input  wire logic [7:0]    ERR_MSG,
  input  wire logic          ERR_BEEP,
  input  wire logic          SAMPLE_VALID,
  input  wire logic [SW-1:0] SAMPLE,
  input  wire logic          OVER_POS,
  input  wire logic          OVER_NEG,
  input  wire logic          TRIG_MODE,
  output logic               BEEP,
  output logic               PANEL_LOCK,
  output logic               ERR_SUMMARY,
  output logic               PRESET,
  output logic               SMOOTH_VALID,
  output logic [SW-1:0]      SMOOTH_DATA,
  output logic [1:0]         OVERLOAD_INDICATION,
  output logic               SMOOTH_ACTIVE
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                     rst_meta_r, rst_n;  // Reset release chain
  sesq_pkg::sesq_panel_type panel_r;            // Front panel state
  logic                     smo_en_r;           // Smoothing enable
  logic [6:0]               fluc_r;             // Threshold setting
  logic [PW-1:0]            pts_r;              // Point count setting
  logic                     beep_en_r;          // Beeper enable
  logic                     int_err;            // Internal error this cycle
  logic [15:0]              int_code;
  logic [7:0]               int_msg;
  logic                     wr_cmd;             // Decoded command write
  sesq_pkg::sesq_cmd_type   cmd;
  logic [31:0]              rd_word;            // Read mux
  sesq_eq_if                eq ();

  // Inclusive range test shared by every setting check
  function automatic logic in_rng(input logic [31:0] v, input logic [31:0] lo,
                                  input logic [31:0] hi);
    return v >= lo && v <= hi;
  endfunction : in_rng

  ////////////////////////////////////////////////////////////////////////
  // Reset release: asserts at once, releases after two edges
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command and setting checks
  assign wr_cmd = WR && ADDR == sesq_pkg::OFF_CMD;
  assign cmd    = sesq_pkg::sesq_cmd_type'(WDATA[2:0]);

  // A bad setting or unknown command makes an internal error record
  always_comb begin
    int_err  = 1'b0;
    int_code = sesq_pkg::ERR_RANGE;
    int_msg  = sesq_pkg::MSG_RANGE;
    if (wr_cmd) begin
      if (WDATA[31:3] != '0 || !(cmd inside {sesq_pkg::CMD_CLS, sesq_pkg::CMD_LOCAL,
          sesq_pkg::CMD_LOCK, sesq_pkg::CMD_PRESET, sesq_pkg::CMD_RST})) begin
        int_err  = 1'b1;
        int_code = sesq_pkg::ERR_UNDEF;
        int_msg  = sesq_pkg::MSG_UNDEF;
      end
    end else if (WR && ADDR == sesq_pkg::OFF_SMO) begin
      int_err = !in_rng(WDATA, 32'h0, 32'h1);
    end else if (WR && ADDR == sesq_pkg::OFF_FLUC) begin
      int_err = !in_rng(WDATA, 32'h0, 32'(sesq_pkg::FLUC_MAX));
    end else if (WR && ADDR == sesq_pkg::OFF_PTS) begin
      int_err = !in_rng(WDATA, 32'(sesq_pkg::PTS_MIN), 32'(sesq_pkg::PTS_MAX));
    end else if (WR && ADDR == sesq_pkg::OFF_BEEP) begin
      int_err = !in_rng(WDATA, 32'h0, 32'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error queue hookup; an internal error wins over an external one
  assign eq.push      = int_err || ERR_VALID;
  assign eq.push_code = int_err ? int_code : ERR_CODE;
  assign eq.push_msg  = int_err ? int_msg : ERR_MSG;
  assign eq.pop       = RD && ADDR == sesq_pkg::OFF_ERR;
  assign eq.clear     = wr_cmd && cmd == sesq_pkg::CMD_CLS;

  sesq_err_queue #(
    .DEPTH (sesq_pkg::EQ_DEPTH)
  ) u_queue (
    .clk   (REF_CLK),
    .rst_n (rst_n),
    .q     (eq)
  );

  ////////////////////////////////////////////////////////////////////////
  // Settings; neither preset nor clear status touches them
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      smo_en_r  <= sesq_pkg::SMO_RST;
      fluc_r    <= sesq_pkg::FLUC_RST;
      pts_r     <= PW'(sesq_pkg::PTS_RST);
      beep_en_r <= sesq_pkg::BEEP_RST;
    end else if (WR && !int_err) begin
      if (ADDR == sesq_pkg::OFF_SMO) begin
        smo_en_r <= WDATA[0];
      end else if (ADDR == sesq_pkg::OFF_FLUC) begin
        fluc_r <= WDATA[6:0];
      end else if (ADDR == sesq_pkg::OFF_PTS) begin
        pts_r <= WDATA[PW-1:0];
      end else if (ADDR == sesq_pkg::OFF_BEEP) begin
        beep_en_r <= WDATA[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Front panel state machine
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      panel_r <= sesq_pkg::PANEL_LOCAL;
    end else if (wr_cmd) begin
      case (panel_r)
        sesq_pkg::PANEL_LOCAL: begin
          if (cmd == sesq_pkg::CMD_LOCK) panel_r <= sesq_pkg::PANEL_REMOTE;
        end
        sesq_pkg::PANEL_REMOTE: begin
          if (cmd == sesq_pkg::CMD_LOCAL) panel_r <= sesq_pkg::PANEL_LOCAL;
        end
        default: panel_r <= sesq_pkg::PANEL_LOCAL;
      endcase
    end
  end

  // Lock output gates the key scanner outside this block
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) PANEL_LOCK <= 1'b0;
    else PANEL_LOCK <= (panel_r == sesq_pkg::PANEL_REMOTE);
  end

  ////////////////////////////////////////////////////////////////////////
  // Preset and factory reset share one pulse, so they cannot drift apart
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) PRESET <= 1'b0;
    else PRESET <= wr_cmd && (cmd == sesq_pkg::CMD_PRESET || cmd == sesq_pkg::CMD_RST);
  end

  ////////////////////////////////////////////////////////////////////////
  // One beep per syntax or hardware error, only when enabled
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) BEEP <= 1'b0;
    else BEEP <= beep_en_r && (int_err || (ERR_VALID && ERR_BEEP));
  end

  // Summary bit for the status byte logic
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) ERR_SUMMARY <= 1'b0;
    else ERR_SUMMARY <= eq.count != '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_word = '0;
    if (ADDR == sesq_pkg::OFF_ERR) begin
      // Number and message index; text is built as number,"message"
      rd_word[sesq_pkg::ERR_CODE_LSB +: 16] = eq.head_code;
      rd_word[7:0] = eq.head_msg;
    end else if (ADDR == sesq_pkg::OFF_STAT) begin
      rd_word[sesq_pkg::STAT_LOCK_BIT] = panel_r == sesq_pkg::PANEL_REMOTE;
      rd_word[sesq_pkg::STAT_SUM_BIT] = eq.count != '0;
      rd_word[sesq_pkg::STAT_ACT_BIT] = SMOOTH_ACTIVE;
      rd_word[sesq_pkg::STAT_CNT_LSB +: 5] = eq.count;
    end else if (ADDR == sesq_pkg::OFF_SMO) begin
      rd_word[0] = smo_en_r;
    end else if (ADDR == sesq_pkg::OFF_FLUC) begin
      rd_word[6:0] = fluc_r;
    end else if (ADDR == sesq_pkg::OFF_PTS) begin
      rd_word[PW-1:0] = pts_r;
    end else if (ADDR == sesq_pkg::OFF_BEEP) begin
      rd_word[0] = beep_en_r;
    end else if (ADDR == sesq_pkg::OFF_VERS) begin
      rd_word = {VERS_YEAR, 8'h00, VERS_REV};
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) RDATA <= '0;
    else RDATA <= RD ? rd_word : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Smoothing engine
  sesq_smooth #(
    .SW (SW),
    .PW (PW)
  ) u_smooth (
    .clk      (REF_CLK),
    .rst_n    (rst_n),
    .smo_en   (smo_en_r),
    .fluc     (fluc_r),
    .pts      (pts_r),
    .trig     (TRIG_MODE),
    .s_valid  (SAMPLE_VALID),
    .s_data   (SAMPLE),
    .ov_pos   (OVER_POS),
    .ov_neg   (OVER_NEG),
    .o_valid  (SMOOTH_VALID),
    .o_data   (SMOOTH_DATA),
    .o_ovl    (OVERLOAD_INDICATION),
    .o_active (SMOOTH_ACTIVE)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!rst_n);

  sequence lock_cmd_s;
    wr_cmd && cmd == sesq_pkg::CMD_LOCK;
  endsequence

  sequence release_cmd_s;
    wr_cmd && cmd == sesq_pkg::CMD_LOCAL;
  endsequence

  lock_enter_a: assert property (lock_cmd_s |=> ##1 PANEL_LOCK)
    else $error("lock command did not lock the panel");
  lock_release_a: assert property (release_cmd_s |=> ##1 !PANEL_LOCK)
    else $error("release command left the panel locked");
  beep_gate_a: assert property (BEEP |-> $past(beep_en_r))
    else $error("beep while beeper disabled");
  beep_error_a: assert property (beep_en_r && ERR_VALID && ERR_BEEP |=> BEEP)
    else $error("error without beep");
  range_keep_a: assert property (WR && ADDR == sesq_pkg::OFF_PTS && int_err
    |=> $stable(pts_r) && eq.count != '0)
    else $error("bad point count accepted");
  preset_keep_a: assert property (PRESET |-> $stable(smo_en_r) && $stable(fluc_r))
    else $error("preset changed smoothing settings");
  summary_a: assert property (eq.count != '0 |=> ERR_SUMMARY)
    else $error("summary bit missing");
  rdata_idle_a: assert property (!RD |=> RDATA == 32'h0000_0000)
    else $error("read data outside its cycle");
endmodule : sesq_top

// ===== test/sesq_err_src.sv
`timescale 1ns/100ps
module sesq_err_src (
  input  wire logic   clk,
  output logic        valid,
  output logic [15:0] code,
  output logic        beep
);
  // Lines start idle at time zero
  initial begin
    valid = 1'b0;
    code  = 16'h0000;
    beep  = 1'b0;
  end
  // One record per cycle; an idle code line shows the inverse of the last code
  task automatic burst(input int n, input logic [15:0] base, input logic b);
    for (int i = 0; i < n; i++) begin
      valid <= 1'b1;
      code  <= base + 16'(i);
      beep  <= b;
      @(posedge clk);
    end
    valid <= 1'b0;
    code  <= ~(base + 16'(n - 1));
    // Let one edge pass so a following burst never re-drives valid in this step
    @(posedge clk);
  endtask : burst
endmodule : sesq_err_src

// ===== test/test_system_error_queue_and_smoothing.sv
`timescale 1ns/100ps
module test_system_error_queue_and_smoothing;
  logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, sv = 1'b0, op = 1'b0;
  logic        trig = 1'b0, ev, eb, beep, lock, summ, pre, act, sval;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] ec;
  logic [23:0] sd = 24'h0, sdat;
  logic [1:0]  ovl;
  int          miscompares = 0, tests_run = 0, beeps = 0, presets = 0;
  sesq_err_src sesq_err_src_i (.clk(clk), .valid(ev), .code(ec), .beep(eb));
  sesq_top sesq_top_i (.REF_CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .ERR_VALID(ev), .ERR_CODE(ec), .ERR_MSG(ec[7:0]),
    .ERR_BEEP(eb), .SAMPLE_VALID(sv), .SAMPLE(sd), .OVER_POS(op), .OVER_NEG(1'b0),
    .TRIG_MODE(trig), .BEEP(beep), .PANEL_LOCK(lock), .ERR_SUMMARY(summ), .PRESET(pre),
    .SMOOTH_VALID(sval), .SMOOTH_DATA(sdat), .OVERLOAD_INDICATION(ovl), .SMOOTH_ACTIVE(act));
  always #5 clk = ~clk;
  // Pulses are counted at the edge so a short pulse is never missed
  always @(posedge clk) begin
    beeps   += int'(beep === 1'b1);
    presets += int'(pre === 1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
    // Strobe is never lowered and raised again in one time step
    @(posedge clk);
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe, so look mid-cycle
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
    @(posedge clk);
  endtask : rd_reg
  task automatic smp(input logic [23:0] x, input logic o, input logic [31:0] exp);
    sv <= 1'b1;
    sd <= x;
    op <= o;
    @(posedge clk);
    sv <= 1'b0;
    sd <= ~x;
    op <= 1'b0;
    @(negedge clk);
    // Valid pulse stands in this cycle only, beside data and overload code
    chk({sval, 5'h00, ovl, sdat}, {1'b1, exp[30:0]});
    @(posedge clk);
  endtask : smp
  task automatic test_done;
    if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // Hang guard, far beyond the roughly 150 cycles the sequence needs
  initial begin
    #100000;
    miscompares++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(sesq_pkg::OFF_PTS, 32'h0000000A);
    rd_reg(sesq_pkg::OFF_FLUC, 32'h0000000A);
    rd_reg(sesq_pkg::OFF_SMO, 32'h00000000);
    rd_reg(sesq_pkg::OFF_VERS, 32'h07CF0000);
    rd_reg(sesq_pkg::OFF_ERR, 32'h00000000);
    sesq_err_src_i.burst(20, 16'hFF00, 1'b1);
    sesq_err_src_i.burst(1, 16'hFF40, 1'b0);
    repeat (2) @(posedge clk);
    chk(32'(beeps), 32'h00000014);
    rd_reg(sesq_pkg::OFF_STAT, 32'h00001402);
    wr_reg(sesq_pkg::OFF_CMD, 32'h00000004);
    rd_reg(sesq_pkg::OFF_PTS, 32'h0000000A);
    chk(32'(presets), 32'h00000001);
    for (int i = 0; i < 19; i++) rd_reg(sesq_pkg::OFF_ERR, {16'hFF00 + 16'(i), 8'h00, 8'(i)});
    rd_reg(sesq_pkg::OFF_ERR, {sesq_pkg::ERR_OVF, 8'h00, sesq_pkg::MSG_OVF});
    rd_reg(sesq_pkg::OFF_ERR, 32'h00000000);
    chk({31'h0, summ}, 32'h00000000);
    wr_reg(sesq_pkg::OFF_BEEP, 32'h00000000);
    wr_reg(sesq_pkg::OFF_PTS, 32'h000007D0);
    rd_reg(sesq_pkg::OFF_PTS, 32'h0000000A);
    sesq_err_src_i.burst(1, 16'hFF50, 1'b1);
    repeat (2) @(posedge clk);
    chk(32'(beeps), 32'h00000014);
    rd_reg(sesq_pkg::OFF_ERR, {sesq_pkg::ERR_RANGE, 8'h00, sesq_pkg::MSG_RANGE});
    wr_reg(sesq_pkg::OFF_CMD, 32'h00000001);
    rd_reg(sesq_pkg::OFF_ERR, 32'h00000000);
    wr_reg(sesq_pkg::OFF_CMD, 32'h00000003);
    rd_reg(sesq_pkg::OFF_STAT, 32'h00000001);
    chk({31'h0, lock}, 32'h00000001);
    wr_reg(sesq_pkg::OFF_CMD, 32'h00000002);
    rd_reg(sesq_pkg::OFF_STAT, 32'h00000000);
    wr_reg(sesq_pkg::OFF_SMO, 32'h00000001);
    wr_reg(sesq_pkg::OFF_FLUC, 32'h00000000);
    wr_reg(sesq_pkg::OFF_PTS, 32'h00000002);
    smp(24'd10, 1'b0, 32'd10);
    smp(24'd20, 1'b0, 32'd15);
    smp(24'd5, 1'b1, 32'h01000000);
    smp(24'd40, 1'b0, 32'd40);
    wr_reg(sesq_pkg::OFF_FLUC, 32'h0000000A);
    smp(24'd80, 1'b0, 32'd80);
    trig <= 1'b1;
    @(posedge clk);
    rd_reg(sesq_pkg::OFF_STAT, 32'h00000000);
    trig <= 1'b0;
    @(posedge clk);
    rd_reg(sesq_pkg::OFF_STAT, 32'h00000004);
    test_done;
  end
endmodule : test_system_error_queue_and_smoothing
